// File: rtl/ipoc_cfg.svh
// Constants for the interrupt pin output control block
`ifndef IPOC_CFG_SVH
`define IPOC_CFG_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define IPOC_OFF_CTRL          12'h000
`define IPOC_CTRL_RESET        32'h00000000

// ****************************************************************
// Field positions of irq_output_control
// ****************************************************************
`define IPOC_INTERVAL_MSB      31
`define IPOC_INTERVAL_LSB      24
`define IPOC_RESTART_BIT       14
`define IPOC_HOLD_BIT          13
`define IPOC_LINE_BIT          12
`define IPOC_PIN_EN_BIT        8
`define IPOC_POLARITY_BIT      4
`define IPOC_CLK_OUT_BIT       1
`define IPOC_DRIVER_BIT        0

// ****************************************************************
// Timing
// ****************************************************************
`define IPOC_CLK_PERIOD_NS     100
`define IPOC_INTERVAL_UNIT_NS  10000
`define IPOC_TICK_CYCLES       (`IPOC_INTERVAL_UNIT_NS / `IPOC_CLK_PERIOD_NS)

`endif

// File: rtl/ipoc_pkg.sv
// Types shared by the interrupt pin output control block
package ipoc_pkg;

  // Pin driver type
  typedef enum logic {
    IPOC_OPEN_DRAIN,
    IPOC_PUSH_PULL
  } ipoc_drv_t;

  // De-assertion interval state
  typedef enum logic {
    IPOC_PASS,
    IPOC_HOLD
  } ipoc_ivl_t;

endpackage : ipoc_pkg

// File: rtl/ipoc_tick.sv
// Prescaler that produces the interval unit enable pulse
module ipoc_tick #(
  parameter int DIV = 100
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Control
  input  wire logic restart,
  // Enable pulse
  output logic      tick
);

  localparam int CW = $clog2(DIV);

  logic [CW-1:0] cnt_reg;

  // Restart aligns the first pulse to a full unit after a fresh start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end else if (restart) begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end else if (cnt_reg == CW'(DIV - 1)) begin
      cnt_reg <= '0;
      tick    <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
      tick    <= 1'b0;
    end
  end

endmodule : ipoc_tick

// File: rtl/ipoc_top.sv
// Interrupt pin output control with APB register access
//
// Contract
// [R1] Control register at offset zero, resets zero
// [R2] Bits 31:24 set interval, 10 us units
// [R3] Zero interval disables, clears counter, releases pending
// [R4] Non-zero interval applies to later interrupts
// [R5] Restart bit 14 reloads a fresh interval
// [R6] Restart bit self-clears; writing zero ignored
// [R7] Software reset keeps restart bit
// [R8] Bit 13 reads one while interval runs
// [R9] Bit 12 shows internal line, ignores enable
// [R10] Bit 8 gates interrupts onto pin
// [R11] Bit 4 selects push-pull active level
// [R12] Open-drain ignores polarity, active low
// [R13] Polarity and driver survive digital reset
// [R14] Bit 1 puts crystal clock on pin
// [R15] Host selects push-pull with clock out
// [R16] Bit 0 selects open-drain or push-pull
// [R17] Host writes reserved bits as zero
// [R18] Interval starts when pin goes inactive
// [R19] Power event bypasses the interval
// [R20] Internal line is OR of enabled flags
// [R21] Pin asserts: line, enable, no interval
// [R22] Prescaled 10 us tick counts interval down
//
// Chosen here: register access over APB.
`include "ipoc_cfg.svh"

module ipoc_top #(
  parameter int NSRC    = 8,
  parameter int PWR_SRC = 1,
  parameter int TICK    = `IPOC_TICK_CYCLES
) (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Lesser resets, one-cycle pulses
  input  wire logic        digital_reset,
  input  wire logic        soft_reset,
  // Interrupt sources
  input  wire logic [NSRC-1:0] irq_flags,
  input  wire logic [NSRC-1:0] irq_enables,
  // Debug clock
  input  wire logic        xtal_clk,
  // Interrupt pin
  input  wire logic        irq_pin_i,
  output logic             irq_pin_o,
  output logic             irq_pin_oe
);
  import ipoc_pkg::*;

  // ****************************************************************
  // Control state
  // ****************************************************************
  logic [7:0]  interval_reg;
  logic        restart_pend_reg;
  logic        pin_en_reg;
  logic        pin_polarity_reg;
  logic        pin_clock_out_reg;
  ipoc_drv_t   pin_driver_type_reg;
  ipoc_ivl_t   ivl_state_reg;
  logic [7:0]  ivl_cnt_reg;
  logic        pin_assert_reg;
  logic        pin_active_reg;
  logic        tick;
  logic        tick_restart;

  // ****************************************************************
  // APB decode
  // ****************************************************************
  logic        acc;
  logic        hit;
  logic        wr_acc;
  logic        rd_acc;
  logic        lesser_rst;

  // A transfer completes at the edge where our registered pready is seen
  assign acc        = psel && penable && pready;
  assign hit        = (paddr[11:2] == 10'(`IPOC_OFF_CTRL >> 2));                 // [R1]
  assign wr_acc     = acc && pwrite && hit;
  assign rd_acc     = psel && penable && !pready && !pwrite;
  assign lesser_rst = digital_reset || soft_reset;

  // ****************************************************************
  // Internal line
  // ****************************************************************
  logic        line;
  logic        pwr_line;
  logic        assert_next;
  logic        fall;
  logic        pin_act_next;

  // Every enabled source feeds the line; the power source alone bypasses holds
  assign line        = |(irq_flags & irq_enables);                               // [R20]
  assign pwr_line    = irq_flags[PWR_SRC] && irq_enables[PWR_SRC];               // [R19]
  assign assert_next = pin_en_reg &&                                             // [R10]
                       (pwr_line || (line && ivl_state_reg == IPOC_PASS));      // [R21]
  assign fall        = pin_assert_reg && !assert_next;                          // [R18]
  assign pin_act_next = pin_clock_out_reg ? xtal_clk : assert_next;             // [R14]

  // Read view of the control register; reserved bits read zero
  function automatic logic [31:0] ctrl_view(input logic hold, input logic ln);
    logic [31:0] v;
    v = `IPOC_CTRL_RESET;
    v[`IPOC_INTERVAL_MSB:`IPOC_INTERVAL_LSB] = interval_reg;
    v[`IPOC_RESTART_BIT]  = restart_pend_reg;
    v[`IPOC_HOLD_BIT]     = hold;                                                // [R8]
    v[`IPOC_LINE_BIT]     = ln;                                                  // [R9]
    v[`IPOC_PIN_EN_BIT]   = pin_en_reg;
    v[`IPOC_POLARITY_BIT] = pin_polarity_reg;
    v[`IPOC_CLK_OUT_BIT]  = pin_clock_out_reg;
    v[`IPOC_DRIVER_BIT]   = (pin_driver_type_reg == IPOC_PUSH_PULL);
    return v;
  endfunction : ctrl_view

  // ****************************************************************
  // APB answer: one wait state, registered data and error
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= !hit;
      prdata  <= (rd_acc && hit) ? ctrl_view(ivl_state_reg == IPOC_HOLD, line)
                                 : 32'h00000000;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ****************************************************************
  // Control fields cleared by every reset
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interval_reg      <= 8'h00;                                                // [R1]
      pin_en_reg        <= 1'b0;
      pin_clock_out_reg <= 1'b0;
    end else if (lesser_rst) begin
      interval_reg      <= 8'h00;
      pin_en_reg        <= 1'b0;
      pin_clock_out_reg <= 1'b0;
    end else if (wr_acc) begin
      interval_reg      <= pwdata[`IPOC_INTERVAL_MSB:`IPOC_INTERVAL_LSB];        // [R2]
      pin_en_reg        <= pwdata[`IPOC_PIN_EN_BIT];
      pin_clock_out_reg <= pwdata[`IPOC_CLK_OUT_BIT];
    end
  end

  // ****************************************************************
  // Pin style: only the system reset clears it
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_polarity_reg    <= 1'b0;                                               // [R13]
      pin_driver_type_reg <= IPOC_OPEN_DRAIN;
    end else if (wr_acc) begin
      pin_polarity_reg    <= pwdata[`IPOC_POLARITY_BIT];                         // [R11]
      pin_driver_type_reg <= pwdata[`IPOC_DRIVER_BIT] ? IPOC_PUSH_PULL           // [R16]
                                                      : IPOC_OPEN_DRAIN;
    end
  end

  // ****************************************************************
  // Restart request: held one cycle, or on through a software reset, then cleared by hardware
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restart_pend_reg <= 1'b0;
    end else if (digital_reset) begin
      restart_pend_reg <= 1'b0;
    end else if (wr_acc && pwdata[`IPOC_RESTART_BIT]) begin
      restart_pend_reg <= 1'b1;                                                  // [R5]
    end else if (!soft_reset) begin
      restart_pend_reg <= 1'b0;                                                  // [R6] [R7]
    end
  end

  // ****************************************************************
  // Interval engine
  // ****************************************************************
  logic zero_wr;

  // A zero interval write wins over a restart in the same cycle
  assign zero_wr      = wr_acc && (pwdata[`IPOC_INTERVAL_MSB:`IPOC_INTERVAL_LSB] == 8'h00);
  assign tick_restart = restart_pend_reg || (fall && interval_reg != 8'h00);

  ipoc_tick #(
    .DIV     (TICK)
  ) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .restart (tick_restart),
    .tick    (tick)
  );

  // Count down in whole 10 us units from the programmed value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ivl_state_reg <= IPOC_PASS;
      ivl_cnt_reg   <= 8'h00;
    end else if (lesser_rst || zero_wr) begin
      ivl_state_reg <= IPOC_PASS;                                                // [R3]
      ivl_cnt_reg   <= 8'h00;
    end else if (restart_pend_reg || (fall && interval_reg != 8'h00)) begin
      ivl_state_reg <= (interval_reg != 8'h00) ? IPOC_HOLD : IPOC_PASS;          // [R5] [R18]
      ivl_cnt_reg   <= interval_reg;                                             // [R4]
    end else begin
      unique case (ivl_state_reg)
        IPOC_PASS: begin
          ivl_cnt_reg <= 8'h00;
        end
        IPOC_HOLD: begin
          if (tick) begin
            ivl_cnt_reg <= ivl_cnt_reg - 8'h01;                                  // [R22]
            if (ivl_cnt_reg <= 8'h01) begin
              ivl_state_reg <= IPOC_PASS;
            end
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Pin driver, registered so the pin never glitches on decode
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_assert_reg <= 1'b0;
      pin_active_reg <= 1'b0;
      irq_pin_o      <= 1'b0;
      irq_pin_oe     <= 1'b0;
    end else begin
      pin_assert_reg <= assert_next;
      pin_active_reg <= pin_act_next;
      if (pin_driver_type_reg == IPOC_PUSH_PULL) begin
        irq_pin_o  <= pin_polarity_reg ? pin_act_next : !pin_act_next;           // [R11]
        irq_pin_oe <= 1'b1;
      end else begin
        // Shared line: only ever pull low, the polarity bit has no say
        irq_pin_o  <= 1'b0;                                                      // [R12]
        irq_pin_oe <= pin_act_next;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_fall_armed;
    (interval_reg != 8'h00) && pin_assert_reg && !assert_next && !wr_acc
      && !restart_pend_reg && !lesser_rst;
  endsequence

  sequence s_restart_armed;
    restart_pend_reg && (interval_reg != 8'h00) && !wr_acc && !lesser_rst;
  endsequence

  property p_restart_selfclr;
    @(posedge pclk) disable iff (!presetn)
      restart_pend_reg && !(wr_acc && pwdata[`IPOC_RESTART_BIT]) && !soft_reset
        |=> !restart_pend_reg;
  endproperty
  a_restart_selfclr: assert property (p_restart_selfclr)                         // [R6]
    else $error("restart bit did not clear itself");

  // A pending restart must ride through a software reset
  property p_restart_kept;
    @(posedge pclk) disable iff (!presetn)
      restart_pend_reg && soft_reset && !digital_reset |=> restart_pend_reg;
  endproperty
  a_restart_kept: assert property (p_restart_kept)                               // [R7]
    else $error("software reset dropped the restart bit");

  property p_restart_load;
    @(posedge pclk) disable iff (!presetn)
      s_restart_armed |=> ivl_state_reg == IPOC_HOLD && ivl_cnt_reg == $past(interval_reg);
  endproperty
  a_restart_load: assert property (p_restart_load)                               // [R5]
    else $error("restart did not reload the interval");

  property p_zero_clears;
    @(posedge pclk) disable iff (!presetn)
      zero_wr |=> ivl_state_reg == IPOC_PASS && ivl_cnt_reg == 8'h00;
  endproperty
  a_zero_clears: assert property (p_zero_clears)                                 // [R3]
    else $error("zero interval write left the counter running");

  property p_fall_starts;
    @(posedge pclk) disable iff (!presetn)
      s_fall_armed |=> ivl_state_reg == IPOC_HOLD ##0 ivl_cnt_reg == $past(interval_reg);
  endproperty
  a_fall_starts: assert property (p_fall_starts)                                 // [R18]
    else $error("interval did not start when the pin went inactive");

  property p_count_on_tick;
    @(posedge pclk) disable iff (!presetn)
      ivl_state_reg == IPOC_HOLD && !tick && !wr_acc && !restart_pend_reg && !lesser_rst
        && !fall |=> $stable(ivl_cnt_reg);
  endproperty
  a_count_on_tick: assert property (p_count_on_tick)                             // [R22]
    else $error("interval counter moved without a tick");

  property p_status_read;
    @(posedge pclk) disable iff (!presetn)
      rd_acc && hit |=> prdata[`IPOC_HOLD_BIT] == $past(ivl_state_reg == IPOC_HOLD)
        && prdata[`IPOC_LINE_BIT] == $past(line);
  endproperty
  a_status_read: assert property (p_status_read)                                 // [R8] [R9]
    else $error("status bits read back wrong");

  property p_gate;
    @(posedge pclk) disable iff (!presetn)
      !pin_en_reg && !pin_clock_out_reg |=> !pin_active_reg;
  endproperty
  a_gate: assert property (p_gate)                                               // [R10]
    else $error("pin active while output disabled");

  property p_hold_withheld;
    @(posedge pclk) disable iff (!presetn)
      ivl_state_reg == IPOC_HOLD && !pwr_line && !pin_clock_out_reg |=> !pin_active_reg;
  endproperty
  a_hold_withheld: assert property (p_hold_withheld)                             // [R21]
    else $error("interrupt reached the pin during the interval");

  property p_power_bypass;
    @(posedge pclk) disable iff (!presetn)
      pwr_line && pin_en_reg && !pin_clock_out_reg |=> pin_active_reg;
  endproperty
  a_power_bypass: assert property (p_power_bypass)                               // [R19]
    else $error("power event held back by the interval");

  property p_open_drain;
    @(posedge pclk) disable iff (!presetn)
      pin_driver_type_reg == IPOC_OPEN_DRAIN |=> !irq_pin_o && irq_pin_oe == pin_active_reg;
  endproperty
  a_open_drain: assert property (p_open_drain)                                   // [R12]
    else $error("open-drain pin driven high");

  property p_push_pull;
    @(posedge pclk) disable iff (!presetn)
      pin_driver_type_reg == IPOC_PUSH_PULL |=> irq_pin_oe
        && irq_pin_o == ($past(pin_polarity_reg) ? pin_active_reg : !pin_active_reg);
  endproperty
  a_push_pull: assert property (p_push_pull)                                     // [R11]
    else $error("push-pull level does not follow polarity");

  property p_style_kept;
    @(posedge pclk) disable iff (!presetn)
      lesser_rst && !wr_acc |=> $stable(pin_polarity_reg) && $stable(pin_driver_type_reg);
  endproperty
  a_style_kept: assert property (p_style_kept)                                   // [R13]
    else $error("pin style lost on a lesser reset");

endmodule : ipoc_top

// File: testbench/ipoc_host_model.sv
// Host side of the interrupt pin: pull-up wire and level decoder
module ipoc_host_model (
  // Pin drive from the block
  input  wire logic pin_o,
  input  wire logic pin_oe,
  // Level that the host treats as a request
  input  wire logic active_high,
  // Wire as the host sees it
  output logic      pin_level,
  output logic      pin_asserted
);
  // Pull-up holds a released line high, so open-drain idle is never unknown
  assign pin_level    = pin_oe ? pin_o : 1'b1;
  assign pin_asserted = (pin_level === active_high);
endmodule : ipoc_host_model

// File: testbench/irq_pin_output_control_tb.sv
// Self-checking bench for the interrupt pin output control block
`include "ipoc_cfg.svh"

module irq_pin_output_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        digital_reset, soft_reset, xtal_clk, pin_o, pin_oe;
  logic        act_hi, lvl, pin_act, err;
  logic [7:0]  flags, enables;
  int          n_errors, n_compared, n, k;
  logic [2:0]  cfg [5];
  logic        exp_lvl [5];

  // ****************************************************************
  // Block, host and stimulus clocks
  // ****************************************************************
  ipoc_top #(.TICK(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .digital_reset(digital_reset), .soft_reset(soft_reset),
    .irq_flags(flags), .irq_enables(enables), .xtal_clk(xtal_clk),
    .irq_pin_i(lvl), .irq_pin_o(pin_o), .irq_pin_oe(pin_oe));
  ipoc_host_model host (.pin_o(pin_o), .pin_oe(pin_oe), .active_high(act_hi),
    .pin_level(lvl), .pin_asserted(pin_act));

  // 100 ns system clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Crystal stand-in toggles each cycle so a clock on the pin is visible
  always @(posedge pclk) begin
    xtal_clk <= ~xtal_clk;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic final_report();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [31:0] ctl(input logic [7:0] ivl, input logic rs,
      input logic en, input logic pol, input logic ck, input logic drv);
    return {ivl, 9'h000, rs, 5'h00, en, 3'h0, pol, 2'h0, ck, drv};
  endfunction : ctl

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (i >= 20) begin
      chk(1'b0, 1'b1);
      final_report();
    end
  endtask : apb

  // Counts cycles until the host sees the wanted request state
  task automatic wait_act(input logic want, input int lim);
    n = 0;
    while (pin_act !== want && n < lim) begin
      @(posedge pclk);
      n++;
    end
    if (n >= lim) begin
      chk(1'b0, 1'b1);
      final_report();
    end
  endtask : wait_act

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic sc_reset_map();
    apb(0, `IPOC_OFF_CTRL, 0);
    chk(rd, `IPOC_CTRL_RESET);
    chk(err, 1'b0);
    apb(0, 12'h010, 0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
  endtask : sc_reset_map

  // Enable, polarity and driver combinations with one source active
  task automatic sc_pin_modes();
    cfg = '{3'b000, 3'b110, 3'b111, 3'b101, 3'b011};
    exp_lvl = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    flags   <= 8'h01;
    enables <= 8'hFF;
    for (k = 0; k < 5; k++) begin
      apb(1, `IPOC_OFF_CTRL, ctl(0, 0, cfg[k][2], cfg[k][1], 0, cfg[k][0]));
      repeat (3) @(posedge pclk);
      chk(lvl, exp_lvl[k]);
    end
    apb(0, `IPOC_OFF_CTRL, 0);
    chk(rd[12], 1'b1);
    enables <= 8'hFE;
    apb(0, `IPOC_OFF_CTRL, 0);
    chk(rd[12], 1'b0);
    enables <= 8'hFF;
  endtask : sc_pin_modes

  // Interval of two units of four cycles, push-pull active high
  task automatic sc_interval();
    act_hi = 1'b1;
    apb(1, `IPOC_OFF_CTRL, ctl(2, 0, 1, 1, 0, 1));
    wait_act(1, 10);
    @(posedge pclk);
    flags <= 8'h00;
    @(posedge pclk);
    flags <= 8'h01;
    repeat (2) @(posedge pclk);
    chk(pin_act, 1'b0);
    wait_act(1, 30);
    chk(n >= 3 && n <= 9, 1'b1);
    @(posedge pclk);
    flags <= 8'h00;
    apb(0, `IPOC_OFF_CTRL, 0);
    chk(rd[13:12], 2'b10);
    flags <= 8'h02;
    wait_act(1, 3);
    @(posedge pclk);
    flags <= 8'h00;
    @(posedge pclk);
    flags <= 8'h01;
    apb(1, `IPOC_OFF_CTRL, ctl(2, 1, 1, 1, 0, 1));
    wait_act(1, 30);
    chk(n >= 8 && n <= 12, 1'b1);
    apb(0, `IPOC_OFF_CTRL, 0);
    chk(rd, ctl(2, 0, 1, 1, 0, 1) | 32'h1000);
    @(posedge pclk);
    flags <= 8'h00;
    @(posedge pclk);
    flags <= 8'h01;
    apb(1, `IPOC_OFF_CTRL, ctl(0, 0, 1, 1, 0, 1));
    wait_act(1, 3);
  endtask : sc_interval

  // Crystal clock on the pin; push-pull is selected with it
  task automatic sc_clock_out();
    logic prev;
    flags <= 8'h00;
    apb(1, `IPOC_OFF_CTRL, ctl(0, 0, 0, 0, 1, 1));
    n = 0;
    prev = lvl;
    repeat (10) begin
      @(posedge pclk);
      if (lvl !== prev) n++;
      prev = lvl;
    end
    chk(n >= 4, 1'b1);
    apb(1, `IPOC_OFF_CTRL, ctl(0, 0, 0, 0, 0, 1));
    repeat (3) @(posedge pclk);
    chk(lvl, 1'b1);
  endtask : sc_clock_out

  // Lesser resets keep polarity and driver; system reset clears them
  task automatic sc_resets();
    apb(1, `IPOC_OFF_CTRL, ctl(3, 0, 1, 1, 0, 1));
    @(posedge pclk);
    digital_reset <= 1'b1;
    @(posedge pclk);
    digital_reset <= 1'b0;
    apb(0, `IPOC_OFF_CTRL, 0);
    chk(rd, 32'h00000011);
    soft_reset <= 1'b1;
    @(posedge pclk);
    soft_reset <= 1'b0;
    apb(0, `IPOC_OFF_CTRL, 0);
    chk(rd, 32'h00000011);
    // Restart written, then a software reset in the very next cycle
    apb(1, `IPOC_OFF_CTRL, ctl(0, 1, 0, 1, 0, 1));
    soft_reset <= 1'b1;
    @(posedge pclk);
    soft_reset <= 1'b0;
    @(posedge pclk);
    chk(dut.restart_pend_reg, 1'b1);
    do_reset();
    apb(0, `IPOC_OFF_CTRL, 0);
    chk(rd, 32'h0);
  endtask : sc_resets

  // Main sequence; every input gets a value at time zero
  initial begin
    {psel, penable, pwrite, digital_reset, soft_reset, xtal_clk} = '0;
    {paddr, pwdata, flags, enables} = '0;
    act_hi = 1'b0;
    presetn = 1'b0;
    n_errors = 0;
    n_compared = 0;
    do_reset();
    sc_reset_map();
    sc_pin_modes();
    sc_interval();
    sc_clock_out();
    sc_resets();
    final_report();
  end
endmodule : irq_pin_output_control_tb
